// ---- hw/rxe_byte_if.sv ----
/*
  byte handshake between the frame logic and the serial shifters.
  assumes both ends on clk_sys.
*/
`timescale 1ns/1ps
interface rxe_byte_if;
  logic       valid;  // byte offered
  logic       ready;  // taker can accept
  logic [7:0] data;   // byte value
  logic       err;    // byte framing fault, with valid
  modport src (output valid, output data, output err, input ready);
  modport snk (input valid, input data, input err, output ready);
endinterface

// ---- hw/rxe_pkg.sv ----
/*
  shared constants for the serial reference exchange block.
  assumes a 25 MHz system clock and a fixed line rate.
*/
package rxe_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned BAUD          = 19_200;
  localparam int unsigned BAUD_DIV      = CLK_HZ / BAUD;
  localparam int unsigned HALF_DIV      = BAUD_DIV / 2;
  localparam int unsigned TX_PERIOD_US  = 5_000;
  localparam int unsigned TX_PERIOD_CYC = (CLK_HZ / 1_000_000) * TX_PERIOD_US;

  // ----------------------------------------
  // register map (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_RATIO   = 8'h04;
  localparam logic [7:0] OFS_SRC     = 8'h08;
  localparam logic [7:0] OFS_DEST    = 8'h0C;
  localparam logic [7:0] OFS_IN_MON  = 8'h10;
  localparam logic [7:0] OFS_OUT_MON = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_MASK    = 8'h1C;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int unsigned CTRL_ROLE  = 0;  // 1 = master
  localparam int unsigned CTRL_SIGN  = 1;  // 1 = invert
  localparam int unsigned CTRL_REPLY = 2;  // master expects a return
  localparam int unsigned ST_RX      = 0;
  localparam int unsigned ST_TX      = 1;
  localparam int unsigned ST_ERR     = 2;
  localparam logic [2:0]  CTRL_RST   = 3'h0;
  localparam logic [15:0] RATIO_ONE  = 16'h2710;  // 1.0000
  localparam logic [15:0] RATIO_MAX  = 16'h7530;  // 3.0000, also 300.00 %
  localparam logic [9:0]  SRC_MAX    = 10'h2D0;   // 720
  localparam logic [9:0]  SRC_DISC   = 10'h190;   // 400
  localparam logic [7:0]  SYNC_BYTE  = 8'h5A;
endpackage

// ---- hw/rxe_top.sv ----
/*
  serial reference exchange: sends one selected value per frame and
  receives, scales and forwards a value from the chain.
  assumes an ahb-lite master on clk_sys, a single word per transfer,
  and the system's parameter store outside providing src_value for
  the index on src_index and taking dest_value at dest_index.
*/
`timescale 1ns/1ps
module rxe_top #(
  parameter int unsigned TX_PERIOD_CYC = rxe_pkg::TX_PERIOD_CYC
) (
  input  wire logic        clk_sys,     // 25 MHz system clock
  input  wire logic        resetn,      // async reset, low
  input  wire logic        hsel,        // ahb slave select
  input  wire logic [31:0] haddr,       // ahb address
  input  wire logic [1:0]  htrans,      // ahb transfer type
  input  wire logic        hwrite,      // ahb write
  input  wire logic [2:0]  hsize,       // ahb size, word only
  input  wire logic [31:0] hwdata,      // ahb write data
  input  wire logic        hready,      // ahb bus ready
  output logic             hreadyout,   // always ready
  output logic             hresp,       // always okay
  output logic [31:0]      hrdata,      // ahb read data
  input  wire logic        rxd,         // serial in from chain
  output logic             txd,         // serial out to chain
  output logic             irq,         // level interrupt
  output logic [9:0]       src_index,   // selected source index
  input  wire logic [15:0] src_value,   // value of selected source
  output logic [9:0]       dest_index,  // selected destination index
  output logic [15:0]      dest_value,  // scaled received value
  output logic             dest_strobe  // pulse: dest_value new next cycle
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  // receive side hunts for sync; transmit side sends four bytes
  typedef enum logic [1:0] {R_SYNC, R_HI, R_LO, R_CHK} rxe_rxf_type;
  typedef enum logic [1:0] {T_IDLE, T_SEND} rxe_txf_type;

  // software view: configuration, monitors and status
  logic [2:0]  ctrl_q;
  logic [15:0] ratio_q;
  logic [9:0]  src_q;
  logic [9:0]  dest_q;
  logic [15:0] in_mon_q;
  logic [15:0] out_mon_q;
  logic [2:0]  stat_q;
  logic [2:0]  mask_q;
  logic [31:0] hrdata_q;
  // bus phase, pin synchroniser and link bookkeeping
  logic [7:0]  addr_q;
  logic        wr_q;
  logic        rxd_m_q;
  logic        rxd_s_q;
  logic [31:0] per_q;
  logic        await_q;
  rxe_rxf_type rxf_q;
  logic [7:0]  hi_q;
  logic [7:0]  lo_q;
  rxe_txf_type txf_q;
  logic [1:0]  tix_q;
  logic [15:0] tval_q;
  logic [15:0] dval_q;
  logic        dstb_q;

  // byte handshakes to the serial shifters
  rxe_byte_if tx_b ();
  rxe_byte_if rx_b ();

  // ----------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------
  wire        ahb_go = hsel & htrans[1] & hready;
  wire        wr_go  = wr_q;
  wire [15:0] wv     = hwdata[15:0];
  wire        w_ctrl = wr_go & (addr_q == rxe_pkg::OFS_CTRL);
  wire        w_rat  = wr_go & (addr_q == rxe_pkg::OFS_RATIO);
  wire        w_src  = wr_go & (addr_q == rxe_pkg::OFS_SRC);
  wire        w_dst  = wr_go & (addr_q == rxe_pkg::OFS_DEST);
  wire        w_st   = wr_go & (addr_q == rxe_pkg::OFS_STATUS);
  wire        w_msk  = wr_go & (addr_q == rxe_pkg::OFS_MASK);

  // ratio held within +/-3.0000 so software cannot leave the range;
  // the whole word is compared so that a large write cannot wrap
  wire        wv_hi   = $signed(hwdata) > $signed({16'h0000, rxe_pkg::RATIO_MAX});
  wire        wv_lo   = $signed(hwdata) < -$signed({16'h0000, rxe_pkg::RATIO_MAX});
  wire [15:0] wv_clip = wv_hi ? rxe_pkg::RATIO_MAX
                      : (wv_lo ? 16'(-$signed(rxe_pkg::RATIO_MAX)) : wv);

  // read selection on the address phase, data stands in data phase
  wire [7:0]  ra = haddr[7:0];
  wire [31:0] rd_mux =
      (ra == rxe_pkg::OFS_CTRL)    ? {29'h0000_0000, ctrl_q} :
      (ra == rxe_pkg::OFS_RATIO)   ? {{16{ratio_q[15]}}, ratio_q} :
      (ra == rxe_pkg::OFS_SRC)     ? {22'h00_0000, src_q} :
      (ra == rxe_pkg::OFS_DEST)    ? {22'h00_0000, dest_q} :
      (ra == rxe_pkg::OFS_IN_MON)  ? {{16{in_mon_q[15]}}, in_mon_q} :
      (ra == rxe_pkg::OFS_OUT_MON) ? {{16{out_mon_q[15]}}, out_mon_q} :
      (ra == rxe_pkg::OFS_STATUS)  ? {29'h0000_0000, stat_q} :
      (ra == rxe_pkg::OFS_MASK)    ? {29'h0000_0000, mask_q} :
      32'h0000_0000;

  // no wait states and no error response
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // address phase capture
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_q     <= 1'b0;
      addr_q   <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q   <= ahb_go & hwrite;
      addr_q <= haddr[7:0];
      if (ahb_go & !hwrite) hrdata_q <= rd_mux;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_q  <= rxe_pkg::CTRL_RST;   // slave, non-invert
      ratio_q <= rxe_pkg::RATIO_ONE;
      src_q   <= rxe_pkg::SRC_DISC;
      dest_q  <= rxe_pkg::SRC_DISC;
      mask_q  <= 3'h0;
    end else begin
      if (w_ctrl) ctrl_q  <= hwdata[2:0];
      if (w_rat)  ratio_q <= wv_clip;
      if (w_src)  src_q   <= hwdata[9:0];
      if (w_dst)  dest_q  <= hwdata[9:0];
      if (w_msk)  mask_q  <= hwdata[2:0];
    end
  end

  // ----------------------------------------
  // pin sync and link byte engines
  // ----------------------------------------
  // two flip-flops before the receiver reads the pin
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end else begin
      rxd_m_q <= rxd;
      rxd_s_q <= rxd_m_q;
    end
  end

  // both shifters use the same fixed baud divisor
  rxe_uart_tx u_tx (.clk_sys(clk_sys), .resetn(resetn), .b(tx_b), .txd(txd));
  rxe_uart_rx u_rx (.clk_sys(clk_sys), .resetn(resetn), .rxd_s(rxd_s_q), .b(rx_b));
  assign rx_b.ready = 1'b1;

  // ----------------------------------------
  // receive framing: sync, high, low, check
  // ----------------------------------------
  // the receive side runs the same way in either role
  wire       is_master = ctrl_q[rxe_pkg::CTRL_ROLE];
  wire       rx_byte   = rx_b.valid & !rx_b.err;
  wire [7:0] chk_exp   = rxe_pkg::SYNC_BYTE ^ hi_q ^ lo_q;
  wire       frame_ok  = rx_byte & (rxf_q == R_CHK) & (rx_b.data == chk_exp);
  // byte fault, missing sync or wrong check byte
  wire       frame_bad = (rx_b.valid & rx_b.err)
                       | (rx_byte & (rxf_q == R_SYNC) & (rx_b.data != rxe_pkg::SYNC_BYTE))
                       | (rx_byte & (rxf_q == R_CHK) & (rx_b.data != chk_exp));

  // a bad byte always drops back to hunting for sync
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxf_q <= R_SYNC;
      hi_q  <= 8'h00;
      lo_q  <= 8'h00;
    end else if (rx_b.valid & rx_b.err) begin
      rxf_q <= R_SYNC;
    end else if (rx_byte) begin
      unique case (rxf_q)
        R_SYNC: if (rx_b.data == rxe_pkg::SYNC_BYTE) rxf_q <= R_HI;
        R_HI: begin
          hi_q  <= rx_b.data;
          rxf_q <= R_LO;
        end
        R_LO: begin
          lo_q  <= rx_b.data;
          rxf_q <= R_CHK;
        end
        R_CHK: rxf_q <= R_SYNC;
      endcase
    end
  end

  // ----------------------------------------
  // scaling, sign and destination
  // ----------------------------------------
  // fixed point, 10000 per unit; division truncates to zero
  wire signed [15:0] rx_val = $signed({hi_q, lo_q});
  wire signed [31:0] prod   = rx_val * $signed(ratio_q);
  wire signed [31:0] quo    = prod / 32'sd10000;
  wire               q_hi   = quo > $signed({16'h0000, rxe_pkg::RATIO_MAX});
  wire               q_lo   = quo < -$signed({16'h0000, rxe_pkg::RATIO_MAX});
  wire        [15:0] q_sat  = q_hi ? rxe_pkg::RATIO_MAX
                            : (q_lo ? 16'(-$signed(rxe_pkg::RATIO_MAX)) : quo[15:0]);
  wire        [15:0] q_sgn  = ctrl_q[rxe_pkg::CTRL_SIGN] ? 16'(-$signed(q_sat)) : q_sat;

  // destination side of the parameter store
  assign dest_index  = dest_q;
  assign dest_value  = dval_q;
  assign dest_strobe = dstb_q;

  // value captured one cycle after the check byte, both roles
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      in_mon_q <= 16'h0000;
      dval_q   <= 16'h0000;
      dstb_q   <= 1'b0;
    end else begin
      dstb_q <= frame_ok;
      if (frame_ok) in_mon_q <= {hi_q, lo_q};
      if (dstb_q)   dval_q   <= q_sgn;
    end
  end

  // ----------------------------------------
  // transmit: period timer, source and frame
  // ----------------------------------------
  // period must exceed a frame, else ticks that fall inside a frame are lost
  wire        per_tick = (per_q == TX_PERIOD_CYC - 1);
  wire        src_ok   = (src_q <= rxe_pkg::SRC_MAX) & (src_q != rxe_pkg::SRC_DISC);
  wire [15:0] out_val  = src_ok ? src_value : 16'h0000;  // disconnected sends zero
  // slave answers only a good frame; a master never waits on one
  wire        tx_req   = is_master ? per_tick : frame_ok;
  wire        tx_start = tx_req & (txf_q == T_IDLE);
  wire        miss     = is_master & per_tick & await_q;

  // limitation: src_value is taken once, as the frame starts
  assign src_index  = src_q;
  assign tx_b.valid = (txf_q == T_SEND);
  assign tx_b.err   = 1'b0;
  assign tx_b.data  = (tix_q == 2'd0) ? rxe_pkg::SYNC_BYTE :
                      (tix_q == 2'd1) ? tval_q[15:8] :
                      (tix_q == 2'd2) ? tval_q[7:0] :
                      rxe_pkg::SYNC_BYTE ^ tval_q[15:8] ^ tval_q[7:0];

  // free running period counter, used only in the master role
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) per_q <= 32'h0000_0000;
    else         per_q <= per_tick ? 32'h0000_0000 : per_q + 32'h0000_0001;
  end

  // frame sender; a request while busy is dropped, not queued
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txf_q     <= T_IDLE;
      tix_q     <= 2'd0;
      tval_q    <= 16'h0000;
      out_mon_q <= 16'h0000;
    end else if (tx_start) begin
      txf_q     <= T_SEND;
      tix_q     <= 2'd0;
      tval_q    <= out_val;
      out_mon_q <= out_val;
    end else if (tx_b.valid & tx_b.ready) begin
      tix_q <= tix_q + 2'd1;
      if (tix_q == 2'd3) txf_q <= T_IDLE;
    end
  end

  // reply watch: a reply must land before the next period tick
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) await_q <= 1'b0;
    else if (tx_start & is_master & ctrl_q[rxe_pkg::CTRL_REPLY]) await_q <= 1'b1;
    else if (frame_ok | !is_master) await_q <= 1'b0;
  end

  // ----------------------------------------
  // status and interrupt, write one to clear, set wins
  // ----------------------------------------
  // bit 2 error, bit 1 send started, bit 0 frame taken
  wire [2:0] st_set = {frame_bad | miss, tx_start, frame_ok};
  wire [2:0] st_clr = w_st ? hwdata[2:0] : 3'h0;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) stat_q <= 3'h0;
    else         stat_q <= (stat_q & ~st_clr) | st_set;
  end

  // level output; software clears the cause, not the line
  assign irq = |(stat_q & mask_q);
endmodule

// ---- hw/rxe_uart_rx.sv ----
/*
  8n1 serial receiver, samples mid bit.
  assumes rxd_s is already synchronised to clk_sys.
*/
`timescale 1ns/1ps
module rxe_uart_rx (
  input  wire logic clk_sys,  // system clock
  input  wire logic resetn,   // async reset, low
  input  wire logic rxd_s,    // synchronised serial in
  rxe_byte_if.src   b         // received bytes
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rxe_rx_type;
  rxe_rx_type  st_q;
  logic [15:0] div_q;
  logic [2:0]  bits_q;
  logic [7:0]  sh_q;
  logic        vld_q;
  logic        err_q;
  wire         half = (div_q == 16'(rxe_pkg::HALF_DIV - 1));
  wire         full = (div_q == 16'(rxe_pkg::BAUD_DIV - 1));

  assign b.valid = vld_q;
  assign b.data  = sh_q;
  assign b.err   = err_q;

  // a glitch shorter than half a bit is dropped at the start check
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= RX_IDLE;  div_q <= 16'h0000;  bits_q <= 3'h0;
      sh_q <= 8'h00;    vld_q <= 1'b0;      err_q  <= 1'b0;
    end else begin
      vld_q <= 1'b0;
      div_q <= div_q + 16'h0001;
      unique case (st_q)
        RX_IDLE: begin
          div_q <= 16'h0000;
          if (!rxd_s) st_q <= RX_START;
        end
        RX_START: if (half) begin
          div_q  <= 16'h0000;
          bits_q <= 3'h0;
          st_q   <= rxd_s ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (full) begin
          div_q  <= 16'h0000;
          sh_q   <= {rxd_s, sh_q[7:1]};
          bits_q <= bits_q + 3'h1;
          if (bits_q == 3'h7) st_q <= RX_STOP;
        end
        RX_STOP: if (full) begin
          vld_q <= 1'b1;
          err_q <= !rxd_s;
          st_q  <= RX_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- hw/rxe_uart_tx.sv ----
/*
  8n1 serial transmitter, one byte per handshake.
  assumes a fixed divisor from rxe_pkg; txd idles high.
*/
`timescale 1ns/1ps
module rxe_uart_tx (
  input  wire logic   clk_sys,  // system clock
  input  wire logic   resetn,   // async reset, low
  rxe_byte_if.snk     b,        // bytes to send
  output logic        txd       // serial out
);
  logic [9:0]  shift_q;
  logic [3:0]  bits_q;
  logic [15:0] div_q;
  logic        busy_q;
  wire         bit_end = (div_q == 16'(rxe_pkg::BAUD_DIV - 1));

  assign b.ready = !busy_q;
  assign txd     = shift_q[0];

  // load stop, data, start; shift lsb first
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 10'h3FF;
      bits_q  <= 4'h0;
      div_q   <= 16'h0000;
      busy_q  <= 1'b0;
    end else if (!busy_q) begin
      if (b.valid) begin
        shift_q <= {1'b1, b.data, 1'b0};
        busy_q  <= 1'b1;
        bits_q  <= 4'h0;
        div_q   <= 16'h0000;
      end
    end else if (bit_end) begin
      div_q   <= 16'h0000;
      shift_q <= {1'b1, shift_q[9:1]};
      bits_q  <= bits_q + 4'h1;
      busy_q  <= (bits_q != 4'h9);
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
endmodule

// ---- tb/rxe_peer.sv ----
/*
  behavioural far-end unit: sends frames into the block, decodes its frames.
  assumes the 8n1 frame and divisor of rxe_pkg; lines idle high.
*/
`timescale 1ns/1ps
module rxe_peer (
  input  wire logic   clk_sys,  // system clock
  input  wire logic   line_in,  // serial from the block
  output logic        line_out, // serial into the block
  output logic        got,      // pulse: good frame decoded
  output logic [15:0] got_val   // value of that frame
);
  localparam int D = rxe_pkg::BAUD_DIV;
  logic [7:0] b [4];
  initial begin
    line_out = 1'b1;
    got      = 1'b0;
    got_val  = 16'h0000;
  end

  // one byte, bits change just after a clock edge
  task automatic put_byte(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (D) @(posedge clk_sys);
    end
  endtask

  // bad flips bit 0 of the check byte, so the block must refuse the frame
  task automatic send(input logic [15:0] v, input logic bad);
    put_byte(rxe_pkg::SYNC_BYTE);
    put_byte(v[15:8]);
    put_byte(v[7:0]);
    put_byte(rxe_pkg::SYNC_BYTE ^ v[15:8] ^ v[7:0] ^ {7'h00, bad});
  endtask

  // receiver samples mid bit, high byte first
  always begin
    for (int k = 0; k < 4; k++) begin
      @(negedge line_in);
      repeat (D / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (D) @(posedge clk_sys);
        b[k][i] = line_in;
      end
      repeat (D) @(posedge clk_sys);
    end
    if (b[0] == rxe_pkg::SYNC_BYTE && b[3] == (b[0] ^ b[1] ^ b[2])) begin
      got_val <= {b[1], b[2]};
      got     <= 1'b1;
      @(posedge clk_sys);
      got     <= 1'b0;
    end
  end
endmodule

// ---- tb/rxe_properties.sv ----
/*
  concurrent checks on the ports of rxe_top, bound into it.
  assumes a single clk_sys domain and the byte map of rxe_pkg.
*/
`timescale 1ns/1ps
module rxe_properties #(
  parameter int unsigned TX_PERIOD_CYC = 60000
) (
  input wire logic        clk_sys,     // system clock
  input wire logic        resetn,      // async reset, low
  input wire logic        hsel,        // ahb select
  input wire logic [31:0] haddr,       // ahb address
  input wire logic [1:0]  htrans,      // ahb transfer type
  input wire logic        hwrite,      // ahb write
  input wire logic [31:0] hwdata,      // ahb write data
  input wire logic        hready,      // ahb ready
  input wire logic        hreadyout,   // slave ready
  input wire logic        hresp,       // slave response
  input wire logic        txd,         // serial out
  input wire logic [9:0]  src_index,   // source index
  input wire logic [9:0]  dest_index,  // destination index
  input wire logic [15:0] dest_value,  // scaled value
  input wire logic        dest_strobe  // pulse, value new next cycle
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  localparam int LIM = 10 * rxe_pkg::BAUD_DIV;
  logic        ph_q;
  logic        wr_q;
  logic        role_q;
  logic [7:0]  ofs_q;
  logic [15:0] hi_q;
  logic [2:0]  rx_q;
  logic [31:0] mst_q;
  wire         land   = ph_q & wr_q & hready;
  wire  [9:0]  wd10   = hwdata[9:0];
  // a frame starts only after a line idle longer than any byte
  wire         fstart = ~txd & (hi_q >= LIM);

  // track the role from writes, since the checker sees no registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ph_q   <= 1'b0;
      wr_q   <= 1'b0;
      ofs_q  <= 8'h00;
      role_q <= 1'b0;
    end else begin
      ph_q  <= hready ? (hsel & htrans[1]) : ph_q;
      wr_q  <= hready ? hwrite : wr_q;
      ofs_q <= hready ? haddr[7:0] : ofs_q;
      role_q <= (land && ofs_q == rxe_pkg::OFS_CTRL) ? hwdata[rxe_pkg::CTRL_ROLE] : role_q;
    end
  end

  // idle run, cycles since a good frame, cycles of master silence
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hi_q  <= 16'h0000;
      rx_q  <= 3'h7;
      mst_q <= 32'h0000_0000;
    end else begin
      hi_q  <= !txd ? 16'h0000 : (hi_q >= LIM) ? hi_q : hi_q + 16'h0001;
      rx_q  <= dest_strobe ? 3'h0 : (rx_q == 3'h7) ? rx_q : rx_q + 3'h1;
      mst_q <= (!role_q || !txd) ? 32'h0000_0000 : mst_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_echo(logic [7:0] ofs, logic [9:0] idx);
    land && ofs_q == ofs |=> idx == $past(wd10);
  endproperty

  a_src_echo: assert property (p_echo(rxe_pkg::OFS_SRC, src_index))
    else $error("source index does not follow its write");
  a_dest_echo: assert property (p_echo(rxe_pkg::OFS_DEST, dest_index))
    else $error("destination index does not follow its write");
  a_slave_waits: assert property (fstart && !role_q |-> rx_q <= 3'h4)
    else $error("slave started a frame unprompted");
  a_slave_reply: assert property (dest_strobe && !role_q && fstart == 1'b0 && txd && hi_q >= LIM |-> ##[0:4] !txd)
    else $error("slave reply did not start");
  a_master_pace: assert property (mst_q <= TX_PERIOD_CYC + 4)
    else $error("master missed its send period");
  a_strobe_pulse: assert property (dest_strobe |=> !dest_strobe)
    else $error("destination strobe too long");
  a_dest_cause: assert property (!$stable(dest_value) |-> $past(dest_strobe))
    else $error("destination value changed without strobe");
  a_dest_span: assert property ($signed(dest_value) >= -30000 && $signed(dest_value) <= 30000)
    else $error("scaled value outside three times span");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not ready and okay");
  a_reset_idle: assert property ($rose(resetn) |-> txd && !dest_strobe)
    else $error("line or strobe busy after reset");

  c_rx_frame: cover property (dest_strobe);
  c_slave_tx: cover property (fstart && !role_q);
  c_status_wr: cover property (land && ofs_q == rxe_pkg::OFS_STATUS);
endmodule

bind rxe_top rxe_properties #(.TX_PERIOD_CYC(TX_PERIOD_CYC)) chk_i (.clk_sys, .resetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .txd, .src_index, .dest_index, .dest_value, .dest_strobe);

// ---- tb/tb_top.sv ----
/*
  self-checking bench for rxe_top in slave role against one peer unit.
  assumes the byte map and frame of rxe_pkg and zero wait states.
*/
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0]  RO [8] = '{rxe_pkg::OFS_CTRL, rxe_pkg::OFS_RATIO, rxe_pkg::OFS_SRC, rxe_pkg::OFS_DEST,
                                     rxe_pkg::OFS_IN_MON, rxe_pkg::OFS_OUT_MON, rxe_pkg::OFS_STATUS, 8'h20};
  localparam logic [31:0] RV [8] = '{32'h0000_0000, {16'h0000, rxe_pkg::RATIO_ONE}, {22'h00_0000, rxe_pkg::SRC_DISC},
                                     {22'h00_0000, rxe_pkg::SRC_DISC}, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                     32'h0000_0000};
  logic        clk_sys, resetn, hsel, hwrite, hready, hreadyout, hresp, rxd, txd, irq, dest_strobe, got, rd_ph;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [9:0]  src_index, dest_index;
  logic [15:0] src_value, dest_value, got_val;
  int          failures, comparisons;
  logic [31:0] exp_rd [$];
  logic [15:0] exp_dv [$];
  logic [15:0] exp_tx [$];
  assign hready = hreadyout;

  rxe_top #(.TX_PERIOD_CYC(60000)) dut (.clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .rxd, .txd, .irq, .src_index, .src_value, .dest_index, .dest_value,
    .dest_strobe);
  // peer transmit feeds block receive and back
  rxe_peer peer (.clk_sys, .line_in(txd), .line_out(rxd), .got, .got_val);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one single transfer; address held until ready, data held until ready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h00_0000, a};
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph  <= ~w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd_ph  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    ahb(1'b0, a, 32'h0000_0000);
  endtask

  // watcher: each result takes the oldest note of its kind
  always @(posedge clk_sys) begin
    if (rd_ph === 1'b1 && hready === 1'b1) chk("hrdata", hrdata, exp_rd.pop_front());
    if (got === 1'b1) chk("sent value", {16'h0000, got_val}, {16'h0000, exp_tx.pop_front()});
  end

  // dest_value is new one cycle after the strobe
  always @(posedge clk_sys) begin
    if (dest_strobe === 1'b1) begin
      @(posedge clk_sys);
      chk("dest_value", {16'h0000, dest_value}, {16'h0000, exp_dv.pop_front()});
    end
  end

  initial begin
    repeat (130000) @(posedge clk_sys);
    failures++;
    print_verdict;
  end

  initial begin
    int          v, r, s, d, p;
    logic [15:0] sv;
    {resetn, hsel, hwrite, rd_ph, failures, comparisons} = '0;
    {haddr, hwdata, htrans, src_value} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    void'($urandom(3813));
    chk("src_index", {22'h00_0000, src_index}, {22'h00_0000, rxe_pkg::SRC_DISC});
    for (int i = 0; i < 8; i++) rd(RO[i], RV[i]);
    ahb(1'b1, rxe_pkg::OFS_RATIO, 32'h0000_9C40);
    rd(rxe_pkg::OFS_RATIO, {16'h0000, rxe_pkg::RATIO_MAX});
    r  = int'($urandom_range(60000)) - 30000;
    v  = int'($urandom_range(60000)) - 30000;
    s  = $urandom_range(720);
    s  = (s == 400) ? 401 : s;
    d  = $urandom_range(1023);
    sv = $urandom;
    src_value <= sv;
    ahb(1'b1, rxe_pkg::OFS_RATIO, r);
    ahb(1'b1, rxe_pkg::OFS_SRC, s);
    ahb(1'b1, rxe_pkg::OFS_DEST, d);
    ahb(1'b1, rxe_pkg::OFS_CTRL, 32'h0000_0002);
    ahb(1'b1, rxe_pkg::OFS_MASK, 32'h0000_0004);
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    rd(rxe_pkg::OFS_RATIO, r);
    chk("dest_index", dest_index, d);
    // truncating product, clipped to three, then inverted
    p = v * r / 10000;
    p = (p > 30000) ? 30000 : (p < -30000) ? -30000 : p;
    exp_dv.push_back(16'(-p));
    exp_tx.push_back(sv);
    peer.send(v[15:0], 1'b0);
    repeat (4) @(posedge clk_sys);
    chk("irq masked", irq, 1'b0);
    // corrupt frame sent while the reply goes out
    peer.send(~v[15:0], 1'b1);
    repeat (4) @(posedge clk_sys);
    chk("irq", irq, 1'b1);
    rd(rxe_pkg::OFS_STATUS, 32'h0000_0007);
    rd(rxe_pkg::OFS_IN_MON, v);
    rd(rxe_pkg::OFS_OUT_MON, {{16{sv[15]}}, sv});
    ahb(1'b1, rxe_pkg::OFS_STATUS, 32'h0000_0004);
    @(posedge clk_sys);
    chk("irq cleared", irq, 1'b0);
    rd(rxe_pkg::OFS_STATUS, 32'h0000_0003);
    for (int i = 0; i < 20000 && exp_tx.size() > 0; i++) @(posedge clk_sys);
    chk("reply count", exp_tx.size(), 0);
    print_verdict;
  end
endmodule
